// ---- hw/mpw_regs.svh ----
// register offsets, reset values and fixed codes of the multiphase pwm block
`ifndef MPW_REGS_SVH
`define MPW_REGS_SVH

// register byte offsets
`define MPW_REG_PERIOD   5'h00
`define MPW_REG_STATUS   5'h04
`define MPW_REG_REF      5'h08
`define MPW_REG_AVG      5'h0C
`define MPW_REG_SMP1     5'h10
`define MPW_REG_SMP2     5'h14
`define MPW_REG_SMP3     5'h18

// period register: reset count and lowest accepted count
`define MPW_PERIOD_RST   16'h012C
`define MPW_PERIOD_MIN   16'h000C

// status register field positions
`define MPW_ST_PWM_LSB   0
`define MPW_ST_WIN_LSB   3
`define MPW_ST_ACT_LSB   6
`define MPW_ST_OFF_BIT   9
`define MPW_ST_TBL_LSB   10

// reference levels in 12.5 mV units, then the off, top and anchor codes
`define MPW_T1_BASE      8'h40
`define MPW_T2_BASE      8'h58
`define MPW_T6_BASE      8'h43
`define MPW_CODE_OFF     5'h1F
`define MPW_CODE_TOP     5'h1E
`define MPW_T6_ANCHOR    5'h0A
// anchor plus 31, modulo 32: past 00000 the walk resumes at 11110 and skips 11111
`define MPW_T6_WRAP      5'h09

`endif

// ---- hw/mpw_pkg.sv ----
// types shared by the multiphase pwm block
package mpw_pkg;
	typedef enum logic [3:0] {
		PH_DIS    = 4'b0001,
		PH_FORCED = 4'b0010,
		PH_ARMED  = 4'b0100,
		PH_ON     = 4'b1000
	} mpw_ph_t;
	typedef enum logic [2:0] {
		MD_ONE   = 3'b001,
		MD_TWO   = 3'b010,
		MD_THREE = 3'b100
	} mpw_mode_t;
	typedef enum logic [2:0] {
		TBL_FIRST  = 3'b001,
		TBL_SECOND = 3'b010,
		TBL_SIX    = 3'b100
	} mpw_tbl_t;
endpackage

// ---- hw/mpw_vid_dec.sv ----
// voltage code decoder: code pins to reference level under the active table
`timescale 1ns/1ps
`include "mpw_regs.svh"
module mpw_vid_dec (
	// code and table
	input  wire logic [4:0]       code_i,
	input  wire logic             half_i,
	input  wire mpw_pkg::mpw_tbl_t tbl_i,
	// decoded level, 12.5 mV units
	output logic      [7:0]       level_o,
	output logic                  off_o
);
	logic [4:0] d_top;
	logic [4:0] d_six;

	assign d_top = `MPW_CODE_TOP - code_i;
	// the six-bit table walks downward from its anchor, then wraps to 11110 and on down;
	// the anchor code with half set is the very last step of that walk
	assign d_six = ((code_i < `MPW_T6_ANCHOR) || ((code_i == `MPW_T6_ANCHOR) && !half_i))
		? (`MPW_T6_ANCHOR - code_i) : (`MPW_T6_WRAP - code_i);

	always_comb begin
		off_o = (code_i == `MPW_CODE_OFF);
		case (tbl_i)
			mpw_pkg::TBL_FIRST: begin
				level_o = `MPW_T1_BASE + {2'h0, d_top, 1'b0};
			end
			mpw_pkg::TBL_SECOND: begin
				level_o = `MPW_T2_BASE + {2'h0, d_top, 1'b0};
			end
			mpw_pkg::TBL_SIX: begin
				level_o = `MPW_T6_BASE + {2'h0, d_six, 1'b0} - {7'h0, half_i};
			end
			default: begin
				level_o = 8'h00;
				off_o   = 1'b1;
			end
		endcase
		if (off_o) begin
			level_o = 8'h00;
		end
	end
endmodule // mpw_vid_dec

// ---- hw/mpw_top.sv ----
// multiphase pwm timing, current balance and voltage code decode with avalon registers
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "mpw_regs.svh"
module mpw_top #(
	parameter int PW = 16,
	parameter int CW = 12
) (
	// clock and reset
	input  wire logic          mclk_i,
	input  wire logic          rst_n_i,
	// avalon-mm slave
	input  wire logic [4:0]    avs_address_i,
	input  wire logic          avs_read_i,
	input  wire logic          avs_write_i,
	input  wire logic [31:0]   avs_writedata_i,
	input  wire logic [3:0]    avs_byteenable_i,
	output logic      [31:0]   avs_readdata_o,
	output logic               avs_waitrequest_o,
	// analog side, digitised
	input  wire logic [PW-1:0] error_level_i,
	input  wire logic [CW-1:0] phase_one_current_sense_i,
	input  wire logic [CW-1:0] phase_two_current_sense_i,
	input  wire logic [CW-1:0] phase_three_current_sense_i,
	// straps
	input  wire logic          third_phase_enable_i,
	input  wire logic          phase_two_bootstrap_pin_i,
	input  wire logic          phase_two_switch_node_i,
	input  wire logic          table_select_i,
	// voltage code pins, value and whether something drives them
	input  wire logic [4:0]    voltage_code_i,
	input  wire logic [4:0]    voltage_code_drive_i,
	input  wire logic          half_step_select_i,
	input  wire logic          half_step_drive_i,
	// pulses and drivers
	output logic               phase_one_pulse_o,
	output logic               phase_two_pulse_o,
	output logic               phase_three_pulse_o,
	output logic      [1:0]    upper_gate_o,
	output logic      [1:0]    lower_gate_o,
	// status
	output logic      [2:0]    sample_window_o,
	output logic      [CW-1:0] cycle_average_current_o,
	output logic      [7:0]    reference_level_o,
	output logic               reference_off_o
);
	typedef logic [PW-1:0] pw_t;

	function automatic pw_t loc_time(input pw_t c, input pw_t off, input pw_t p);
		logic [PW:0] s;
		s = {1'b0, c} + {1'b0, p} - {1'b0, off};
		loc_time = (c >= off) ? pw_t'(c - off) : s[PW-1:0];
	endfunction

	function automatic logic [CW-1:0] avg_of(input logic [CW+1:0] s, input mpw_pkg::mpw_mode_t m);
		case (m)
			mpw_pkg::MD_ONE:   avg_of = s[CW-1:0];
			mpw_pkg::MD_TWO:   avg_of = s[CW:1];
			mpw_pkg::MD_THREE: avg_of = CW'(s / 3);
			default:           avg_of = s[CW-1:0];
		endcase
	endfunction

	// period and mode state
	pw_t                   period_r;
	pw_t                   per_cur_r;
	pw_t                   cnt_r;
	mpw_pkg::mpw_mode_t    mode_r;
	mpw_pkg::mpw_mode_t    mode_nxt;
	logic [2:0]            act;
	pw_t                   p2;
	pw_t                   p3;
	pw_t                   p6;
	pw_t                   offs [3];
	pw_t                   tloc [3];
	logic                  wrap;
	// phase state
	mpw_pkg::mpw_ph_t      st_r [3];
	logic [CW-1:0]         smp_r [3];
	logic [CW-1:0]         sns [3];
	logic [CW-1:0]         avg_r;
	logic [2:0]            win_r;
	logic [2:0]            rise;
	logic [2:0]            close;
	logic signed [CW:0]    bal [3];
	logic signed [PW+1:0]  corr [3];
	logic signed [PW+1:0]  ramp [3];
	logic [CW+1:0]         sum;
	// code pins
	logic [4:0]            code_r;
	logic                  half_r;
	mpw_pkg::mpw_tbl_t     tbl_r;
	logic [7:0]            dec_level;
	logic                  dec_off;
	logic [7:0]            ref_r;
	logic                  off_r;
	// bus
	logic                  ack_r;
	logic                  req;
	logic [31:0]           rdata_r;
	logic [31:0]           rmux;
	pw_t                   wr_per;

	assign sns[0] = phase_one_current_sense_i;
	assign sns[1] = phase_two_current_sense_i;
	assign sns[2] = phase_three_current_sense_i;

	// period counter; a new period count and strap mode take effect only at wrap
	// so that the phase offsets never jump inside a cycle
	assign wrap = (cnt_r >= per_cur_r - 16'h0001);
	assign p2   = per_cur_r >> 1;
	assign p3   = pw_t'(per_cur_r / 3);
	assign p6   = pw_t'(per_cur_r / 6);

	always_comb begin
		if (phase_two_bootstrap_pin_i && phase_two_switch_node_i) begin
			mode_nxt = mpw_pkg::MD_ONE;
		end else if (third_phase_enable_i) begin
			mode_nxt = mpw_pkg::MD_TWO;
		end else begin
			mode_nxt = mpw_pkg::MD_THREE;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cnt_r     <= 16'h0000;
			per_cur_r <= `MPW_PERIOD_RST;
			mode_r    <= mpw_pkg::MD_THREE;
		end else if (wrap) begin
			cnt_r     <= 16'h0000;
			per_cur_r <= period_r;
			mode_r    <= mode_nxt;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	always_comb begin
		case (mode_r)
			mpw_pkg::MD_ONE:   act = 3'b001;
			mpw_pkg::MD_TWO:   act = 3'b011;
			mpw_pkg::MD_THREE: act = 3'b111;
			default:           act = 3'b001;
		endcase
		offs[0] = 16'h0000;
		offs[1] = (mode_r == mpw_pkg::MD_THREE) ? p3 : p2;
		offs[2] = p3 + p3;
		for (int k = 0; k < 3; k++) begin
			tloc[k]  = loc_time(cnt_r, offs[k], per_cur_r);
			bal[k]   = $signed({1'b0, smp_r[k]}) - $signed({1'b0, avg_r});
			corr[k]  = $signed({2'b00, error_level_i}) - (PW+2)'(bal[k]);
			ramp[k]  = $signed({2'b00, pw_t'(per_cur_r - 16'h0001 - tloc[k])});
			rise[k]  = (st_r[k] == mpw_pkg::PH_ARMED) && (tloc[k] != 16'h0000) && (corr[k] >= ramp[k]);
			close[k] = (st_r[k] == mpw_pkg::PH_ARMED) && (rise[k] || (tloc[k] == 16'h0000));
		end
	end

	// phase state machines; a termination at local time zero wins over a rise, and a strap-off wins over both
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			for (int k = 0; k < 3; k++) begin
				st_r[k] <= mpw_pkg::PH_DIS;
			end
		end else begin
			for (int k = 0; k < 3; k++) begin
				case (st_r[k])
					mpw_pkg::PH_DIS: begin
						if (act[k]) begin
							st_r[k] <= mpw_pkg::PH_FORCED;
						end
					end
					mpw_pkg::PH_FORCED: begin
						if (!act[k]) begin
							st_r[k] <= mpw_pkg::PH_DIS;
						end else if (tloc[k] >= p3) begin
							st_r[k] <= mpw_pkg::PH_ARMED;
						end
					end
					mpw_pkg::PH_ARMED: begin
						if (!act[k]) begin
							st_r[k] <= mpw_pkg::PH_DIS;
						end else if (tloc[k] == 16'h0000) begin
							st_r[k] <= mpw_pkg::PH_FORCED;
						end else if (rise[k]) begin
							st_r[k] <= mpw_pkg::PH_ON;
						end
					end
					mpw_pkg::PH_ON: begin
						if (!act[k]) begin
							st_r[k] <= mpw_pkg::PH_DIS;
						end else if (tloc[k] == 16'h0000) begin
							st_r[k] <= mpw_pkg::PH_FORCED;
						end
					end
					default: begin
						st_r[k] <= mpw_pkg::PH_DIS;
					end
				endcase
			end
		end
	end

	// sample window and hold
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			win_r <= 3'b000;
			for (int k = 0; k < 3; k++) begin
				smp_r[k] <= '0;
			end
		end else begin
			for (int k = 0; k < 3; k++) begin
				win_r[k] <= act[k] && (((st_r[k] == mpw_pkg::PH_FORCED) && (tloc[k] >= p6))
					|| (st_r[k] == mpw_pkg::PH_ARMED));
				if (close[k]) begin
					smp_r[k] <= sns[k];
				end
			end
		end
	end

	// cycle average, inactive phases add nothing and do not count
	always_comb begin
		sum = '0;
		for (int k = 0; k < 3; k++) begin
			if (act[k]) begin
				sum = sum + {2'b00, smp_r[k]};
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			avg_r <= '0;
		end else if (cnt_r == 16'h0000) begin
			avg_r <= avg_of(sum, mode_r);
		end
	end

	assign phase_one_pulse_o   = (st_r[0] == mpw_pkg::PH_ON);
	assign phase_two_pulse_o   = (st_r[1] == mpw_pkg::PH_ON);
	assign phase_three_pulse_o = (st_r[2] == mpw_pkg::PH_ON);
	// the internal drivers are complementary; a strapped-off phase keeps both gates off
	assign upper_gate_o[0] = phase_one_pulse_o;
	assign lower_gate_o[0] = !phase_one_pulse_o && act[0];
	assign upper_gate_o[1] = phase_two_pulse_o;
	assign lower_gate_o[1] = !phase_two_pulse_o && act[1];
	assign sample_window_o = win_r;
	assign cycle_average_current_o = avg_r;

	// code pins: an undriven pin is pulled up and reads as one
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			code_r <= 5'h1F;
			half_r <= 1'b1;
			tbl_r  <= mpw_pkg::TBL_FIRST;
		end else begin
			code_r <= voltage_code_i | ~voltage_code_drive_i;
			half_r <= half_step_select_i | ~half_step_drive_i;
			if (table_select_i) begin
				tbl_r <= mpw_pkg::TBL_SIX;
			end else if (half_step_select_i | ~half_step_drive_i) begin
				tbl_r <= mpw_pkg::TBL_SECOND;
			end else begin
				tbl_r <= mpw_pkg::TBL_FIRST;
			end
		end
	end

	mpw_vid_dec u_dec (
		.code_i  (code_r),
		.half_i  (half_r),
		.tbl_i   (tbl_r),
		.level_o (dec_level),
		.off_o   (dec_off)
	);

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ref_r <= 8'h00;
			off_r <= 1'b1;
		end else begin
			ref_r <= dec_level;
			off_r <= dec_off;
		end
	end

	assign reference_level_o = ref_r;
	assign reference_off_o   = off_r;

	// avalon slave: one wait state, the access completes on the second edge
	assign req               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req && !ack_r;
	assign avs_readdata_o    = rdata_r;
	assign wr_per = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : period_r[15:8],
		avs_byteenable_i[0] ? avs_writedata_i[7:0] : period_r[7:0]};

	always_comb begin
		rmux = 32'h0000_0000;
		case (avs_address_i)
			`MPW_REG_PERIOD: rmux[PW-1:0] = period_r;
			`MPW_REG_STATUS: begin
				rmux[`MPW_ST_PWM_LSB +: 3] = {phase_three_pulse_o, phase_two_pulse_o, phase_one_pulse_o};
				rmux[`MPW_ST_WIN_LSB +: 3] = win_r;
				rmux[`MPW_ST_ACT_LSB +: 3] = act;
				rmux[`MPW_ST_OFF_BIT]      = off_r;
				rmux[`MPW_ST_TBL_LSB +: 3] = tbl_r;
			end
			`MPW_REG_REF:    rmux[7:0] = ref_r;
			`MPW_REG_AVG:    rmux[CW-1:0] = avg_r;
			`MPW_REG_SMP1:   rmux[CW-1:0] = smp_r[0];
			`MPW_REG_SMP2:   rmux[CW-1:0] = smp_r[1];
			`MPW_REG_SMP3:   rmux[CW-1:0] = smp_r[2];
			default:         rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req && !ack_r;
			if (avs_read_i && !ack_r) begin
				rdata_r <= rmux;
			end
		end
	end

	// too short a period would collapse the third and sixth fractions to zero
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			period_r <= `MPW_PERIOD_RST;
		end else if (avs_write_i && ack_r && (avs_address_i == `MPW_REG_PERIOD)) begin
			period_r <= (wr_per < `MPW_PERIOD_MIN) ? `MPW_PERIOD_MIN : wr_per;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_term_one;
		(cnt_r == 16'h0000) |=> !phase_one_pulse_o;
	endproperty
	a_term_one: assert property (p_term_one) else $error("phase one not low at period start");

	property p_third;
		(mode_r == mpw_pkg::MD_THREE) && (cnt_r == p3) && !wrap |=> !phase_two_pulse_o;
	endproperty
	a_third: assert property (p_third) else $error("phase two not ended a third after phase one");

	property p_half;
		(mode_r == mpw_pkg::MD_TWO) && (cnt_r == p2) && !wrap |=> !phase_two_pulse_o;
	endproperty
	a_half: assert property (p_half) else $error("phase two not ended half a period after phase one");

	property p_forced;
		$rose(phase_one_pulse_o) |-> ($past(tloc[0]) > p3);
	endproperty
	a_forced: assert property (p_forced) else $error("phase one rose inside forced off time");

	property p_hold_high;
		phase_two_pulse_o && (tloc[1] != 16'h0000) && act[1] |=> phase_two_pulse_o;
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("phase two fell before its termination");

	property p_window;
		$rose(sample_window_o[0]) |-> ($past(tloc[0]) == p6) || $past(wrap);
	endproperty
	a_window: assert property (p_window) else $error("sample window opened at the wrong time");

	property p_inactive;
		(mode_r == mpw_pkg::MD_TWO) ##1 (mode_r == mpw_pkg::MD_TWO) |-> !phase_three_pulse_o;
	endproperty
	a_inactive: assert property (p_inactive) else $error("phase three active in two-phase mode");

	property p_single;
		(mode_r == mpw_pkg::MD_ONE) ##1 (mode_r == mpw_pkg::MD_ONE) |-> !phase_two_pulse_o && !lower_gate_o[1];
	endproperty
	a_single: assert property (p_single) else $error("phase two driven in single-phase mode");

	property p_first_top;
		(tbl_r == mpw_pkg::TBL_FIRST) && (code_r == 5'h1E) |=> (ref_r == 8'h40) && !off_r;
	endproperty
	a_first_top: assert property (p_first_top) else $error("first table top code not 0.800 V");

	property p_second_end;
		(tbl_r == mpw_pkg::TBL_SECOND) && (code_r == 5'h00) |=> (ref_r == 8'h94);
	endproperty
	a_second_end: assert property (p_second_end) else $error("second table end code not 1.850 V");
endmodule // mpw_top

// ---- sim/mpw_drv_model.sv ----
// gate driver and current sense model standing at the three phase legs
`timescale 1ns/1ps
module mpw_drv_model (
	// clock
	input  wire logic        mclk_i,
	// gate commands from the controller
	input  wire logic [1:0]  upper_gate_i,
	input  wire logic [1:0]  lower_gate_i,
	input  wire logic        phase_three_pulse_i,
	// load current of each leg
	input  wire logic [11:0] load_one_i,
	input  wire logic [11:0] load_two_i,
	input  wire logic [11:0] load_three_i,
	// sensed currents and shoot-through flag
	output logic      [11:0] sense_one_o,
	output logic      [11:0] sense_two_o,
	output logic      [11:0] sense_three_o,
	output logic             overlap_o
);
	// sensing works only while the lower switch conducts; otherwise the line shows garbage
	assign sense_one_o   = lower_gate_i[0] ? load_one_i : ~load_one_i;
	assign sense_two_o   = lower_gate_i[1] ? load_two_i : ~load_two_i;
	// external driver turns the lower switch on while its pulse is low
	assign sense_three_o = !phase_three_pulse_i ? load_three_i : ~load_three_i;
	logic ovl_r = 1'b0;
	assign overlap_o = ovl_r;
	always_ff @(posedge mclk_i) begin
		if ((upper_gate_i & lower_gate_i) != 2'h0) begin
			ovl_r <= 1'b1;
		end
	end
endmodule // mpw_drv_model

// ---- sim/tb.sv ----
// self-checking bench for the multiphase pwm block
`timescale 1ns/1ps
module tb;
	localparam int P = 12;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic [15:0] err = 16'h00FF;
	logic [11:0] l1 = 12'h01E;
	logic [11:0] l2 = 12'h03C;
	logic [11:0] l3 = 12'h05A;
	logic [11:0] s1, s2, s3, avg;
	logic        tpe = 1'b0;
	logic        bt = 1'b0;
	logic        sw = 1'b0;
	logic        ts = 1'b0;
	logic [5:0]  pin = 6'h1E;
	logic [5:0]  drv = 6'h3F;
	logic        p1, p2, p3, off, ovl;
	logic [1:0]  ug, lg;
	logic [2:0]  win, pv, wv;
	logic [7:0]  lvl;
	logic [31:0] q;
	wire  [2:0]  pls = {p3, p2, p1};
	int          fails = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          gap = 0;
	int          fall[3], wrise[3], hic[3], lowmin[3], h[3];

	always #5 mclk_i = ~mclk_i;

	mpw_top #(.PW(16), .CW(12)) mpw_top_inst (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .error_level_i(err),
		.phase_one_current_sense_i(s1), .phase_two_current_sense_i(s2),
		.phase_three_current_sense_i(s3), .third_phase_enable_i(tpe),
		.phase_two_bootstrap_pin_i(bt), .phase_two_switch_node_i(sw), .table_select_i(ts),
		.voltage_code_i(pin[4:0]), .voltage_code_drive_i(drv[4:0]), .half_step_select_i(pin[5]),
		.half_step_drive_i(drv[5]), .phase_one_pulse_o(p1), .phase_two_pulse_o(p2),
		.phase_three_pulse_o(p3), .upper_gate_o(ug), .lower_gate_o(lg), .sample_window_o(win),
		.cycle_average_current_o(avg), .reference_level_o(lvl), .reference_off_o(off));

	mpw_drv_model mpw_drv_model_inst (
		.mclk_i(mclk_i), .upper_gate_i(ug), .lower_gate_i(lg), .phase_three_pulse_i(p3),
		.load_one_i(l1), .load_two_i(l2), .load_three_i(l3), .sense_one_o(s1),
		.sense_two_o(s2), .sense_three_o(s3), .overlap_o(ovl));

	// edge bookkeeping sampled before each edge's updates land
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		pv <= pls;
		wv <= win;
		for (int k = 0; k < 3; k++) begin
			if (pv[k] === 1'b1 && pls[k] === 1'b0) fall[k] <= cyc;
			if (pv[k] === 1'b0 && pls[k] === 1'b1 && cyc - fall[k] < lowmin[k]) lowmin[k] <= cyc - fall[k];
			if (wv[k] === 1'b0 && win[k] === 1'b1) wrise[k] <= cyc;
			hic[k] <= hic[k] + int'(pls[k] === 1'b1);
		end
		if (cyc == 8000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// holds the request until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge mclk_i);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
	endtask

	// waits n periods, then until the next fall of phase one is recorded, then P - 2 edges more
	task automatic settle(input int n);
		int t;
		repeat (n * P) @(posedge mclk_i);
		t = fall[0];
		for (int i = 0; i < 4 * P && fall[0] == t; i++) @(posedge mclk_i);
		repeat (P - 2) @(posedge mclk_i);
		gap = fall[0] - t;
		for (int k = 0; k < 3; k++) h[k] = hic[k];
	endtask

	task automatic t_regs();
		bus(0, 5'h00, 0);
		chk("period reset", 32'h0000012C, q);
		bus(0, 5'h1C, 0);
		chk("unmapped", 32'h0, q);
		bus(0, 5'h02, 0);
		chk("misaligned", 32'h0, q);
		bus(1, 5'h04, 32'hFFFFFFFF);
		bus(0, 5'h04, 0);
		chk("mask three", 32'h7, 32'(q[8:6]));
		chk("table first", 32'h1, 32'(q[12:10]));
		bus(1, 5'h00, 32'h00000005);
		bus(0, 5'h00, 0);
		chk("period floor", 32'h0000000C, q);
		$display("test registers done");
	endtask

	task automatic t_three();
		for (int k = 0; k < 3; k++) lowmin[k] = 99;
		settle(30);
		chk("period", 32'(P), 32'(gap));
		chk("p2 after p1", 32'(P / 3), 32'(fall[1] - fall[0]));
		chk("p3 after p2", 32'(P / 3), 32'(fall[2] - fall[1]));
		for (int k = 0; k < 3; k++) begin
			chk("off time", 32'h1, 32'(lowmin[k] >= P / 3));
			chk("window", 32'(P / 6), 32'(wrise[k] - fall[k]));
		end
		chk("average", 32'h03C, 32'(avg));
		bus(0, 5'h10, 0);
		chk("sample one", 32'h01E, q);
		repeat (2 * P) @(posedge mclk_i);
		for (int k = 0; k < 3; k++) chk("high each period", 32'h1, 32'(hic[k] - h[k] > 0));
		chk("upper", 32'({p2, p1}), 32'(ug));
		chk("lower", {30'h0, ~p2, ~p1}, 32'(lg));
		$display("test three phase done");
	endtask

	task automatic t_two();
		tpe <= 1'b1;
		settle(3);
		repeat (2 * P) @(posedge mclk_i);
		chk("p2 half", 32'(P / 2), 32'(fall[1] - fall[0]));
		chk("p3 idle", 32'h0, 32'(hic[2] - h[2]));
		chk("average", 32'h02D, 32'(avg));
		bus(0, 5'h04, 0);
		chk("mask two", 32'h3, 32'(q[8:6]));
		$display("test two phase done");
	endtask

	task automatic t_single();
		tpe <= 1'b0;
		bt <= 1'b1;
		sw <= 1'b1;
		settle(3);
		repeat (2 * P) @(posedge mclk_i);
		chk("p2 idle", 32'h0, 32'(hic[1] - h[1]));
		chk("p3 idle", 32'h0, 32'(hic[2] - h[2]));
		chk("p2 lower", 32'h0, 32'(lg[1]));
		chk("average", 32'h01E, 32'(avg));
		bus(0, 5'h04, 0);
		chk("mask one", 32'h1, 32'(q[8:6]));
		bt <= 1'b0;
		sw <= 1'b0;
		$display("test single phase done");
	endtask

	// unequal currents with a low error level: heavier legs get shorter pulses
	task automatic t_balance();
		err <= 16'h0003;
		settle(3);
		repeat (2 * P) @(posedge mclk_i);
		chk("p1 over p2", 32'h1, 32'(hic[0] - h[0] > hic[1] - h[1]));
		chk("p2 over p3", 32'h1, 32'(hic[1] - h[1] > hic[2] - h[2]));
		chk("p3 starved", 32'h0, 32'(hic[2] - h[2]));
		chk("no overlap", 32'h0, 32'(ovl));
		$display("test balance done");
	endtask

	task automatic dec(input logic t, input logic [5:0] d, input logic [5:0] c, input logic eo, input logic [7:0] el);
		@(posedge mclk_i);
		ts <= t;
		drv <= d;
		pin <= c;
		repeat (4) @(posedge mclk_i);
		chk("off", 32'(eo), 32'(off));
		if (!eo) chk("level", 32'(el), 32'(lvl));
	endtask

	task automatic t_decode();
		dec(0, 6'h3F, 6'h1E, 0, 8'h40);
		dec(0, 6'h3F, 6'h00, 0, 8'h7C);
		dec(0, 6'h3F, 6'h1F, 1, 8'h00);
		dec(0, 6'h3F, 6'h3E, 0, 8'h58);
		dec(0, 6'h3F, 6'h3B, 0, 8'h5E);
		bus(0, 5'h04, 0);
		chk("table second", 32'h2, 32'(q[12:10]));
		dec(0, 6'h3F, 6'h20, 0, 8'h94);
		dec(1, 6'h3F, 6'h0A, 0, 8'h43);
		dec(1, 6'h3F, 6'h29, 0, 8'h44);
		dec(1, 6'h3F, 6'h00, 0, 8'h57);
		dec(1, 6'h3F, 6'h3E, 0, 8'h58);
		dec(1, 6'h3F, 6'h2A, 0, 8'h80);
		dec(1, 6'h3F, 6'h1F, 1, 8'h00);
		dec(1, 6'h3F, 6'h3F, 1, 8'h00);
		bus(0, 5'h08, 0);
		chk("ref reg off", 32'h0, 32'(q[7:0]));
		bus(0, 5'h04, 0);
		chk("table six", 32'h4, 32'(q[12:10]));
		dec(0, 6'h1F, 6'h1E, 0, 8'h58);
		dec(0, 6'h3E, 6'h1E, 1, 8'h00);
		dec(0, 6'h00, 6'h00, 1, 8'h00);
		$display("test decode done");
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_three();
		t_two();
		t_single();
		t_balance();
		t_decode();
		wrap_up();
	end
endmodule // tb
